/* rtl/core_sfr_pkg.sv */
// constants and types for the core special-function register block
package core_sfr_pkg;

  localparam logic [7:0] IDX_PORT_ZERO   = 8'h00;
  localparam logic [7:0] IDX_PTR_ZERO    = 8'h01;
  localparam logic [7:0] IDX_PORT_ONE    = 8'h02;
  localparam logic [7:0] IDX_PTR_ONE     = 8'h03;
  localparam logic [7:0] IDX_BANK_SELECT = 8'h04;
  localparam logic [7:0] IDX_WORK        = 8'h05;
  localparam logic [7:0] IDX_PROG_LOW    = 8'h06;
  localparam logic [7:0] IDX_TBL_LOW     = 8'h07;
  localparam logic [7:0] IDX_TBL_RESULT  = 8'h08;
  localparam logic [7:0] IDX_TBL_HIGH    = 8'h09;
  localparam logic [7:0] IDX_STATUS      = 8'h0a;
  localparam logic [7:0] IDX_LAST        = 8'h0a;

  localparam int BIT_CARRY  = 0;
  localparam int BIT_NIBBLE = 1;
  localparam int BIT_ZERO   = 2;
  localparam int BIT_WRAP   = 3;
  localparam int BIT_SLEEP  = 4;
  localparam int BIT_EXPIRY = 5;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic       RESET_BANK = 1'b0;

  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC,
    ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC
  } alu_op_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dm_req_t;

  typedef struct packed {
    alu_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       to_work;
  } alu_req_t;

endpackage : core_sfr_pkg

/* rtl/core_special_registers.sv */
// special-function registers, indirect addressing, flags and apb slave
`timescale 1ns/1ns
`default_nettype none
module core_special_registers
  import core_sfr_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire dm_req_t       dm_req,
  output logic      [7:0]    dm_rdata,
  output logic               dm_rvalid,
  output logic      [8:0]    ram_addr,
  output logic               ram_we,
  output logic      [7:0]    ram_wdata,
  input  wire logic [7:0]    ram_rdata,
  input  wire alu_req_t      alu_req,
  output logic      [7:0]    alu_result,
  input  wire logic [7:0]    pc_low_now,
  output logic               pc_load,
  output logic      [7:0]    pc_load_value,
  output logic               dummy_cycle,
  input  wire logic          tbl_read,
  output logic      [15:0]   prog_addr,
  output logic               prog_req,
  input  wire logic          prog_ack,
  input  wire logic [15:0]   prog_rdata,
  output logic      [7:0]    tbl_low_data,
  output logic               tbl_done,
  input  wire logic          halt_exec,
  input  wire logic          dog_kick_instr,
  input  wire logic          dog_timeout,
  input  wire logic          sys_reset,
  input  wire logic          sys_reset_dog
);

  logic [7:0] pointer_zero;
  logic [7:0] pointer_one;
  logic       bank_sel_bit;
  logic [7:0] work_register;
  logic [7:0] table_ptr_low;
  logic [7:0] table_ptr_high;
  logic [7:0] table_result_high;
  logic [3:0] arith_flags;
  logic       sleep_flag;
  logic       dog_expiry_flag;
  logic       tbl_busy;

  function automatic logic [10:0] add_flags(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic       ci);
    logic [4:0] lo;
    logic [7:0] s7;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
    s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    // {wrap, nibble, carry, sum}
    return {s7[7] ^ s[8], lo[4], s[8], s[7:0]};
  endfunction : add_flags

  function automatic logic [7:0] status_byte(input logic [3:0] f,
                                             input logic       slp,
                                             input logic       exp);
    return {2'b00, exp, slp, f};
  endfunction : status_byte

  // address steering for core accesses
  logic [8:0] eff_addr;
  logic       eff_null;
  logic       eff_sfr;
  always_comb begin
    eff_null = 1'b0;
    if (dm_req.addr == IDX_PORT_ZERO) begin
      eff_addr = {1'b0, pointer_zero};
    end else if (dm_req.addr == IDX_PORT_ONE) begin
      eff_addr = {bank_sel_bit, pointer_one};
    end else begin
      eff_addr = {1'b0, dm_req.addr};
    end
    if ((dm_req.addr == IDX_PORT_ZERO || dm_req.addr == IDX_PORT_ONE) &&
        (eff_addr[7:0] == IDX_PORT_ZERO ||
         eff_addr[7:0] == IDX_PORT_ONE)) begin
      eff_null = 1'b1;
    end
    // bank bit ignored for the special area
    eff_sfr = eff_addr[7:0] <= IDX_LAST;
  end

  function automatic logic [7:0] sfr_read(input logic [7:0] idx,
                                          input logic [7:0] pz,
                                          input logic [7:0] po,
                                          input logic       bk,
                                          input logic [7:0] wk,
                                          input logic [7:0] prog_low_byte,
                                          input logic [7:0] tl,
                                          input logic [7:0] tr,
                                          input logic [7:0] th,
                                          input logic [7:0] st);
    case (idx)
      IDX_PTR_ZERO:    return pz;
      IDX_PTR_ONE:     return po;
      IDX_BANK_SELECT: return {7'h00, bk};
      IDX_WORK:        return wk;
      IDX_PROG_LOW:    return prog_low_byte;
      IDX_TBL_LOW:     return tl;
      IDX_TBL_RESULT:  return tr;
      IDX_TBL_HIGH:    return th;
      IDX_STATUS:      return st;
      default:         return RESET_BYTE; // ports themselves hold nothing
    endcase
  endfunction : sfr_read

  // apb side: core accesses take priority, so apb waits them out
  logic       core_busy;
  logic       apb_access;
  logic [9:0] apb_idx;
  logic       apb_bad;
  assign core_busy  = dm_req.rd | dm_req.wr;
  assign apb_idx    = paddr[11:2];
  assign apb_bad    = (apb_idx > {2'b00, IDX_LAST}) || (paddr[1:0] != 2'b00);
  assign pready     = ~core_busy & ce;
  assign pslverr    = psel & penable & apb_bad;
  assign apb_access = psel & penable & ~core_busy & ce;

  logic [7:0] status_now;
  assign status_now = status_byte(arith_flags, sleep_flag, dog_expiry_flag);

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !apb_bad) begin
      prdata = {24'h000000,
                sfr_read(apb_idx[7:0], pointer_zero, pointer_one,
                         bank_sel_bit, work_register, pc_low_now,
                         table_ptr_low, table_result_high,
                         table_ptr_high, status_now)};
    end
  end

  // single merged write port into the special registers
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = RESET_BYTE;
    wr_data = RESET_BYTE;
    if (dm_req.wr && eff_sfr && !eff_null) begin
      wr_en   = 1'b1;
      wr_idx  = eff_addr[7:0];
      wr_data = dm_req.wdata;
    end else if (apb_access && pwrite && !apb_bad) begin
      wr_en   = 1'b1;
      wr_idx  = apb_idx[7:0];
      wr_data = pwdata[7:0];
    end
  end

  // general memory outside this block
  assign ram_addr  = eff_addr;
  assign ram_we    = ce & dm_req.wr & ~eff_sfr & ~eff_null;
  assign ram_wdata = dm_req.wdata;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dm_rdata  <= RESET_BYTE;
      dm_rvalid <= 1'b0;
    end else if (ce) begin
      dm_rvalid <= dm_req.rd;
      if (dm_req.rd) begin
        if (eff_null) begin
          dm_rdata <= RESET_BYTE;
        end else if (eff_sfr) begin
          dm_rdata <= sfr_read(eff_addr[7:0], pointer_zero, pointer_one,
                               bank_sel_bit, work_register, pc_low_now,
                               table_ptr_low, table_result_high,
                               table_ptr_high, status_now);
        end else begin
          dm_rdata <= ram_rdata;
        end
      end
    end
  end

  // pointers and table pointers: ordinary storage, inc/dec is read-modify
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_zero   <= RESET_BYTE;
      pointer_one    <= RESET_BYTE;
      table_ptr_low  <= RESET_BYTE;
      table_ptr_high <= RESET_BYTE;
    end else if (ce && wr_en) begin
      case (wr_idx)
        IDX_PTR_ZERO: pointer_zero   <= wr_data;
        IDX_PTR_ONE:  pointer_one    <= wr_data;
        IDX_TBL_LOW:  table_ptr_low  <= wr_data;
        IDX_TBL_HIGH: table_ptr_high <= wr_data;
        default: ;
      endcase
    end
  end

  // bank select survives only a watchdog wake from sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_sel_bit <= RESET_BANK;
    end else if (ce) begin
      if (sys_reset) begin
        if (!(sys_reset_dog && sleep_flag)) begin
          bank_sel_bit <= RESET_BANK;
        end
      end else if (wr_en && wr_idx == IDX_BANK_SELECT) begin
        bank_sel_bit <= wr_data[0];
      end
    end
  end

  // alu: results and flags
  logic [10:0] sum;
  logic [7:0]  res;
  logic [3:0]  next_flags;
  always_comb begin
    sum        = 11'h000;
    res        = alu_req.a;
    next_flags = arith_flags;
    case (alu_req.op)
      ALU_ADD: sum = add_flags(alu_req.a, alu_req.b, 1'b0);
      ALU_ADC: sum = add_flags(alu_req.a, alu_req.b, arith_flags[BIT_CARRY]);
      ALU_SUB: sum = add_flags(alu_req.a, ~alu_req.b, 1'b1);
      ALU_SBC: sum = add_flags(alu_req.a, ~alu_req.b, arith_flags[BIT_CARRY]);
      default: ;
    endcase
    case (alu_req.op)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        res                    = sum[7:0];
        next_flags[BIT_CARRY]  = sum[8];
        next_flags[BIT_NIBBLE] = sum[9];
        next_flags[BIT_WRAP]   = sum[10];
        next_flags[BIT_ZERO]   = sum[7:0] == 8'h00;
      end
      ALU_AND, ALU_OR, ALU_XOR: begin
        res = (alu_req.op == ALU_AND) ? (alu_req.a & alu_req.b) :
              (alu_req.op == ALU_OR)  ? (alu_req.a | alu_req.b) :
                                        (alu_req.a ^ alu_req.b);
        next_flags[BIT_ZERO] = res == 8'h00;
      end
      ALU_RLC: begin
        res                   = {alu_req.a[6:0], arith_flags[BIT_CARRY]};
        next_flags[BIT_CARRY] = alu_req.a[7];
      end
      ALU_RRC: begin
        res                   = {arith_flags[BIT_CARRY], alu_req.a[7:1]};
        next_flags[BIT_CARRY] = alu_req.a[0];
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alu_result <= RESET_BYTE;
    end else if (ce && alu_req.op != ALU_NONE) begin
      alu_result <= res;
    end
  end

  // an alu result bound for the work register beats a move into it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      work_register <= RESET_BYTE;
    end else if (ce) begin
      if (alu_req.op != ALU_NONE && alu_req.to_work) begin
        work_register <= res;
      end else if (wr_en && wr_idx == IDX_WORK) begin
        work_register <= wr_data;
      end
    end
  end

  // arithmetic flags; a status write replaces them, system flags untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arith_flags <= 4'h0;
    end else if (ce) begin
      if (wr_en && wr_idx == IDX_STATUS) begin
        arith_flags <= wr_data[BIT_WRAP:BIT_CARRY];
      end else if (alu_req.op != ALU_NONE) begin
        arith_flags <= next_flags;
      end
    end
  end

  // status is not stacked on calls or interrupts, no save path
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleep_flag <= 1'b0;
    end else if (ce) begin
      if (halt_exec) begin
        sleep_flag <= 1'b1;
      end else if (dog_kick_instr) begin
        sleep_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dog_expiry_flag <= 1'b0;
    end else if (ce) begin
      // a time-out in the clearing cycle is kept
      if (dog_timeout) begin
        dog_expiry_flag <= 1'b1;
      end else if (dog_kick_instr || halt_exec) begin
        dog_expiry_flag <= 1'b0;
      end
    end
  end

  // program counter low byte: jump inside the page plus one dummy cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_load       <= 1'b0;
      pc_load_value <= RESET_BYTE;
      dummy_cycle   <= 1'b0;
    end else if (ce) begin
      pc_load     <= wr_en && wr_idx == IDX_PROG_LOW;
      dummy_cycle <= pc_load;
      if (wr_en && wr_idx == IDX_PROG_LOW) begin
        pc_load_value <= wr_data;
      end
    end
  end

  // table read: one outstanding fetch at a time
  assign prog_addr = {table_ptr_high, table_ptr_low};
  assign prog_req  = tbl_busy;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tbl_busy          <= 1'b0;
      tbl_done          <= 1'b0;
      tbl_low_data      <= RESET_BYTE;
      table_result_high <= RESET_BYTE;
    end else if (ce) begin
      tbl_done <= 1'b0;
      if (tbl_busy && prog_ack) begin
        tbl_busy          <= 1'b0;
        tbl_done          <= 1'b1;
        table_result_high <= prog_rdata[15:8];
        tbl_low_data      <= prog_rdata[7:0];
      end else if (tbl_read) begin
        tbl_busy <= 1'b1;
      end else if (wr_en && wr_idx == IDX_TBL_RESULT) begin
        table_result_high <= wr_data;
      end
    end
  end

endmodule : core_special_registers
`default_nettype wire

/* sim/core_sfr_props.sv */
// port checks for the core special-function register block
`timescale 1ns/1ns
`default_nettype none
module core_sfr_props
  import core_sfr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic [31:0] prdata,
  input wire dm_req_t     dm_req,
  input wire logic        dm_rvalid,
  input wire logic [8:0]  ram_addr,
  input wire logic        ram_we,
  input wire logic [7:0]  ram_wdata,
  input wire logic        pc_load,
  input wire logic [7:0]  pc_load_value,
  input wire logic        dummy_cycle,
  input wire logic        prog_req,
  input wire logic        prog_ack,
  input wire logic [15:0] prog_rdata,
  input wire logic [7:0]  tbl_low_data,
  input wire logic        tbl_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic acc;
  assign acc = ce && (dm_req.rd || dm_req.wr);
  chk_direct_bank_zero: assert property (
    acc && dm_req.addr > IDX_LAST |-> ram_addr == {1'b0, dm_req.addr})
    else $error("direct access left bank zero");
  chk_port_zero_bank: assert property (
    acc && dm_req.addr == IDX_PORT_ZERO |-> ram_addr[8] == 1'b0)
    else $error("pair zero reached bank one");
  chk_ram_write_data: assert property (
    ram_we |-> acc && dm_req.wr && ram_wdata == dm_req.wdata)
    else $error("ram write without matching core write");
  chk_read_answer: assert property (
    ce |=> dm_rvalid == $past(dm_req.rd))
    else $error("read answer missing or spurious");
  chk_pcl_load: assert property (
    acc && dm_req.wr && dm_req.addr == IDX_PROG_LOW
    |=> pc_load && pc_load_value == $past(dm_req.wdata))
    else $error("low byte write did not load counter");
  chk_pcl_dummy: assert property (
    ce && pc_load |=> dummy_cycle)
    else $error("no dummy cycle after jump");
  chk_table_split: assert property (
    ce && prog_req && prog_ack |=> tbl_done && !prog_req
    && tbl_low_data == $past(prog_rdata[7:0]))
    else $error("table fetch did not complete");
  chk_upper_zero: assert property (
    psel |-> prdata[31:8] == 24'h0)
    else $error("unimplemented read bits not zero");
  cov_jump: cover property (pc_load ##1 dummy_cycle);
  cov_table: cover property (prog_req ##1 tbl_done);
  cov_port_one: cover property (acc && dm_req.addr == IDX_PORT_ONE);
endmodule : core_sfr_props
`default_nettype wire

/* sim/core_side_model.sv */
// behavioural data ram and program memory beside the register block
`timescale 1ns/1ns
`default_nettype none
module core_side_model (
  input  wire logic [0:0]  clock,
  input  wire logic [8:0]  ram_addr,
  input  wire logic        ram_we,
  input  wire logic [7:0]  ram_wdata,
  output logic      [7:0]  ram_rdata,
  input  wire logic        prog_req,
  input  wire logic [15:0] prog_addr,
  input  wire logic [3:0]  ack_delay,
  output logic             prog_ack,
  output logic      [15:0] prog_rdata
);
  logic [7:0] mem [512];
  logic [3:0] wait_cnt;
  initial begin
    for (int i = 0; i < 512; i++)
      mem[i] = i[7:0] ^ 8'h3c;
  end
  assign ram_rdata = mem[ram_addr];
  always @(posedge clock) begin
    if (ram_we)
      mem[ram_addr] <= ram_wdata;
  end
  // off the ack the word is inverted so a late sample cannot pass
  assign prog_rdata = prog_ack ? prog_addr ^ 16'h5aa5
                               : ~(prog_addr ^ 16'h5aa5);
  always @(posedge clock) begin
    if (!prog_req || prog_ack) begin
      wait_cnt <= 4'h0;
      prog_ack <= 1'b0;
    end else if (wait_cnt == ack_delay)
      prog_ack <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule : core_side_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the core special-function register block
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, seen) begin n_compared++; if ((seen) !== (exp)) \
  begin n_errors++; $display("wrong value %s expected %h seen %h", \
  what, exp, seen); end end
module testbench;
  import core_sfr_pkg::*;
  logic        clock, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic        dm_rvalid, ram_we, pc_load, dummy_cycle, tbl_read, err;
  logic        prog_req, prog_ack, tbl_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0]  ram_addr;
  logic [7:0]  dm_rdata, ram_wdata, ram_rdata, alu_result, pc_low_now;
  logic [7:0]  pc_load_value, tbl_low_data, got;
  logic [15:0] prog_addr, prog_rdata, word;
  logic [4:0]  evt;
  logic [3:0]  ack_delay;
  dm_req_t     dm_req;
  alu_req_t    alu_req;
  int          n_errors, n_compared;
  // alu table: opcode, operands, result, flags {wrap,zero,nibble,carry}
  logic [47:0] opc = 48'h1115_7633_8924;
  logic [95:0] opa = 96'h0f807ff0_55001005_01010100;
  logic [95:0] opb = 96'h0180010f_aa010105_00000100;
  logic [95:0] res = 96'h10008000_ff010f00_030003ff;
  logic [47:0] flg = 48'h2dae_aa17_6700;
  core_special_registers DUT (
    .clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dm_req, .dm_rdata, .dm_rvalid, .ram_addr,
    .ram_we, .ram_wdata, .ram_rdata, .alu_req, .alu_result, .pc_low_now,
    .pc_load, .pc_load_value, .dummy_cycle, .tbl_read, .prog_addr,
    .prog_req, .prog_ack, .prog_rdata, .tbl_low_data, .tbl_done,
    .halt_exec(evt[4]), .dog_kick_instr(evt[3]), .dog_timeout(evt[2]),
    .sys_reset(evt[1]), .sys_reset_dog(evt[0]));
  core_side_model partner (
    .clock, .ram_addr, .ram_we, .ram_wdata, .ram_rdata, .prog_req,
    .prog_addr, .ack_delay, .prog_ack, .prog_rdata);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic apb(input logic wr, input logic [7:0] idx, wd);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    got = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic core(input logic wr, input logic [7:0] a, d);
    @(posedge clock);
    dm_req <= '{~wr, wr, a, d};
    @(posedge clock);
    dm_req <= '0;
    @(negedge clock);
    got = dm_rdata;
  endtask : core
  task automatic pulse(input logic [4:0] m);
    @(posedge clock);
    evt <= m;
    @(posedge clock);
    evt <= 5'h0;
  endtask : pulse
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, tbl_read} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    dm_req = '0;
    alu_req = '0;
    pc_low_now = 8'h9b;
    evt = 5'h0;
    ce = 1'b1;
    ack_delay = 4'h0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'h0, IDX_STATUS, 8'h0);
    `CHECK("status", 8'h00, got)
    apb(1'h1, 8'h0b, 8'h55);
    `CHECK("refused", 1'h1, err)
    apb(1'h1, IDX_BANK_SELECT, 8'hff);
    apb(1'h0, IDX_BANK_SELECT, 8'h0);
    `CHECK("bank", 8'h01, got)
    $display("test registers done");
    core(1'h1, 8'h40, 8'h11);
    core(1'h1, IDX_PTR_ONE, 8'h40);
    core(1'h1, IDX_PORT_ONE, 8'h5a);
    core(1'h0, IDX_PORT_ONE, 8'h0);
    `CHECK("bank one", 8'h5a, got)
    core(1'h0, 8'h40, 8'h0);
    `CHECK("direct", 8'h11, got)
    core(1'h1, IDX_PTR_ZERO, 8'h40);
    core(1'h0, IDX_PORT_ZERO, 8'h0);
    `CHECK("pair zero", 8'h11, got)
    apb(1'h0, IDX_PTR_ZERO, 8'h0);
    `CHECK("pointer", 8'h40, got)
    core(1'h1, IDX_WORK, 8'hc6);
    apb(1'h0, IDX_WORK, 8'h0);
    `CHECK("sfr in bank one", 8'hc6, got)
    apb(1'h1, IDX_BANK_SELECT, 8'h0);
    core(1'h0, IDX_PORT_ONE, 8'h0);
    `CHECK("pair one", 8'h11, got)
    core(1'h1, IDX_PTR_ZERO, IDX_PORT_ONE);
    core(1'h1, IDX_PORT_ZERO, 8'h77);
    core(1'h0, IDX_PORT_ZERO, 8'h0);
    `CHECK("self port", 8'h00, got)
    $display("test indirect done");
    for (int i = 0; i < 12; i++) begin
      @(posedge clock);
      alu_req <= '{alu_op_t'(opc[47-4*i -: 4]), opa[95-8*i -: 8],
                   opb[95-8*i -: 8], 1'b1};
      @(posedge clock);
      alu_req <= '0;
      @(negedge clock);
      `CHECK("alu", res[95-8*i -: 8], alu_result)
      apb(1'h0, IDX_STATUS, 8'h0);
      `CHECK("flags", {4'h0, flg[47-4*i -: 4]}, got)
      apb(1'h0, IDX_WORK, 8'h0);
      `CHECK("work", res[95-8*i -: 8], got)
    end
    $display("test alu done");
    apb(1'h1, IDX_STATUS, 8'h0);
    pulse(5'h10);
    pulse(5'h04);
    apb(1'h1, IDX_STATUS, 8'h0);
    apb(1'h0, IDX_STATUS, 8'h0);
    `CHECK("status write", 8'h30, got)
    apb(1'h1, IDX_STATUS, 8'hff);
    apb(1'h0, IDX_STATUS, 8'h0);
    `CHECK("status all", 8'h3f, got)
    apb(1'h1, IDX_BANK_SELECT, 8'h01);
    pulse(5'h03);
    apb(1'h0, IDX_BANK_SELECT, 8'h0);
    `CHECK("wake keeps bank", 8'h01, got)
    pulse(5'h10);
    apb(1'h0, IDX_STATUS, 8'h0);
    `CHECK("halt", 8'h1f, got)
    pulse(5'h08);
    apb(1'h0, IDX_STATUS, 8'h0);
    `CHECK("kick", 8'h0f, got)
    pulse(5'h03);
    apb(1'h0, IDX_BANK_SELECT, 8'h0);
    `CHECK("reset bank", 8'h00, got)
    // a halt seen while the clock enable is low must leave status alone
    ce <= 1'b0;
    pulse(5'h10);
    ce <= 1'b1;
    apb(1'h0, IDX_STATUS, 8'h0);
    `CHECK("frozen", 8'h0f, got)
    $display("test system flags done");
    core(1'h1, IDX_PROG_LOW, 8'h3c);
    `CHECK("jump", 9'h13c, {pc_load, pc_load_value})
    @(negedge clock);
    `CHECK("dummy", 1'h1, dummy_cycle)
    apb(1'h0, IDX_PROG_LOW, 8'h0);
    `CHECK("counter low", 8'h9b, got)
    for (int j = 0; j < 2; j++) begin
      word = j ? 16'h80ff : 16'h1234;
      ack_delay <= j ? 4'h3 : 4'h0;
      apb(1'h1, IDX_TBL_LOW, word[7:0]);
      apb(1'h1, IDX_TBL_HIGH, word[15:8]);
      tbl_read <= 1'b1;
      @(posedge clock);
      tbl_read <= 1'b0;
      while (tbl_done !== 1'b1)
        @(negedge clock);
      word = word ^ 16'h5aa5;
      `CHECK("table low", word[7:0], tbl_low_data)
      apb(1'h0, IDX_TBL_RESULT, 8'h0);
      `CHECK("table high", word[15:8], got)
    end
    $display("test jump and table done");
    wrap_up();
  end
endmodule : testbench
bind core_special_registers core_sfr_props chk (
  .clock, .rst_n, .ce, .psel, .prdata, .dm_req, .dm_rvalid, .ram_addr,
  .ram_we, .ram_wdata, .pc_load, .pc_load_value, .dummy_cycle, .prog_req,
  .prog_ack, .prog_rdata, .tbl_low_data, .tbl_done);
`default_nettype wire
